/* File: verilog/cdb_defs.vh */
`ifndef CDB_DEFS_VH
`define CDB_DEFS_VH

// register byte addresses on the APB bus
`define CDB_OFS_CNT_LOW    8'h00
`define CDB_OFS_CNT_HIGH   8'h04
`define CDB_OFS_ADDR_LOW   8'h08
`define CDB_OFS_ADDR_MID   8'h0C
`define CDB_OFS_ADDR_TOP   8'h10
`define CDB_OFS_HEAD_LOW   8'h14
`define CDB_OFS_HEAD_MID   8'h18
`define CDB_OFS_HEAD_TOP   8'h1C
`define CDB_OFS_WR_LOW     8'h20
`define CDB_OFS_WR_MID     8'h24
`define CDB_OFS_WR_TOP     8'h28
`define CDB_OFS_TRIGGER    8'h2C
`define CDB_OFS_END_ACK    8'h30
`define CDB_OFS_HDR0       8'h34
`define CDB_OFS_HDR1       8'h38
`define CDB_OFS_HDR2       8'h3C
`define CDB_OFS_HDR3       8'h40
`define CDB_OFS_CTRL       8'h44
`define CDB_OFS_STATUS     8'h48

// decoder control fields
`define CDB_CTRL_DECODE_ENABLE_BIT  7
`define CDB_CTRL_LOOK_BIT   6
`define CDB_CTRL_FIX_BIT    5
`define CDB_CTRL_AUTO_BIT   4
`define CDB_CTRL_ERAS_BIT   3
`define CDB_CTRL_BUFFER_WRITE_REQUEST_BIT   2
`define CDB_CTRL_ECC_BIT    1
`define CDB_CTRL_TEST_BIT   0
`define CDB_CTRL_RESET      8'h00

// transfer address top byte: memory select
`define CDB_ADDR_SEL_BIT    7
// count high byte bit that mirrors the end flag in legacy modes
`define CDB_CNT_FLAG_BIT    7

// block geometry in bytes
`define CDB_BLOCK_LEN       21'h000930
`define CDB_HDR_BYTES       12

// decoder modes
`define CDB_MODE_DISABLED   3'h0
`define CDB_MODE_MONITOR    3'h1
`define CDB_MODE_REPEAT     3'h2
`define CDB_MODE_WRITE      3'h3
`define CDB_MODE_REALTIME   3'h4
`define CDB_MODE_WRITE_LA   3'h5
`define CDB_MODE_REAL_LA    3'h6
`define CDB_MODE_INVALID    3'h7

`endif

/* File: verilog/cdb_hdr_mem.v */
`timescale 1ns/1ps
`default_nettype none

// header byte store: registered read, one write port
module cdb_hdr_mem #(
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  // clock
  input  wire          core_clk,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [7:0]    wr_data,
  // read port
  input  wire [AW-1:0] rd_idx,
  output reg  [7:0]    rd_data
);

  reg [7:0] mem_reg [0:DEPTH-1];

  always @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_idx] <= wr_data;
    end
    rd_data <= mem_reg[rd_idx];
  end

endmodule // cdb_hdr_mem

`default_nettype wire

/* File: verilog/cdb_regs.v */
// Overview of operation
// R01: count 16 bits, legacy 15 plus flag
// R02: count decrements per host read or write
// R03: 21-bit write-only transfer address
// R04: transfer address increments per moved byte
// R05: top address bit 7 selects internal memory
// R06: software reloads address before each transfer
// R07: 21-bit block head pointer, 2352-byte blocks
// R08: head pointer updates at sync when writing
// R09: drive write pointer increments per byte
// R10: top write during writes parks until sector
// R11: trigger write starts transfer, data ignored
// R12: acknowledge write clears end flag
// R13: header select picks header or sub-header
// R14: header bytes uncorrected, tied to head pointer
// R15: reset clears decoder control register
// R16: decode enable gates header capture, correction request and decoder mode; drive writes and internal_ram_enable follow the write request bit alone
// R17: lookahead makes pointers describe next block
// R18: bit 5 corrects upstream mis-corrections
// R19: bit 3 enables erasure flag use
// R20: write request starts writes next block
// R21: correction request enables block correction
// R22: decoder mode follows four control bits
// R23: end flag set at transfer end
// R24: busy set by trigger, cleared at end
// R25: transfer ends when count reaches zero
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cdb_defs.vh"

module cdb_regs (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // host interface mode and transfer events
  input  wire        legacy_mode,
  input  wire        xfer_to_host,
  input  wire        host_read_pulse,
  input  wire        xfer_byte_pulse,
  // drive side events
  input  wire        drive_byte_pulse,
  input  wire        drive_sync_pulse,
  // header capture and status from the decoder
  input  wire        hdr_wr_en,
  input  wire [3:0]  hdr_wr_idx,
  input  wire [7:0]  hdr_wr_data,
  input  wire        subheader_select,
  input  wire [7:0]  header_error_flags,
  // transfer engine
  output reg         xfer_busy_flag,
  output reg         xfer_end_flag,
  output reg  [20:0] xfer_addr,
  output reg         xfer_internal_mem,
  // drive write path
  output reg  [20:0] drive_wr_addr,
  output reg         drive_wr_active,
  output reg         internal_ram_enable,
  // decoder control
  output reg         decode_enable,
  output reg         lookahead,
  output reg         fix_upstream_miscorrections,
  output reg         auto_form_extract,
  output reg         erasure_flag_use,
  output reg         correction_request,
  output reg         factory_test_bit,
  output reg  [2:0]  decoder_mode
);

  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg  [20:0] addr_next;
  reg         busy_next;
  reg         end_next;
  reg  [20:0] head_reg;
  reg  [20:0] head_next;
  reg  [20:0] wr_next;
  reg         park_reg;
  reg         park_next;
  reg         active_next;
  reg  [7:0]  ctrl_reg;
  reg  [31:0] rdata_next;
  reg         err_next;
  wire        acc;
  wire        wr;
  wire        rd;
  wire [3:0]  mem_idx;
  wire [7:0]  mem_rdata;
  wire        buffer_write_request;

  // a write is taken only at the edge where pready is high; a read is taken at the edge before, while pready is low
  assign acc  = psel & penable & pready;
  assign wr   = acc & pwrite;
  assign rd   = psel & penable & ~pready & ~pwrite;
  assign buffer_write_request = ctrl_reg[`CDB_CTRL_BUFFER_WRITE_REQUEST_BIT];

  // header index: sub-header copy from bytes 16..19 when the 20..23 byte is flagged
  function [3:0] hdr_index;
    input [1:0] slot;
    input       sub;
    input [7:0] errs;
    begin
      if (!sub)
      begin
        hdr_index = {2'h0, slot}; // R13
      end
      else if (errs[3 - slot])
      begin
        hdr_index = 4'h4 + {2'h0, slot}; // R13
      end
      else
      begin
        hdr_index = 4'h8 + {2'h0, slot}; // R13
      end
    end
  endfunction

  // mode table; lookahead without write request has no defined mode
  function [2:0] mode_of;
    input [7:0] c;
    begin
      if (!c[`CDB_CTRL_DECODE_ENABLE_BIT])
      begin
        mode_of = `CDB_MODE_DISABLED;
      end
      else
      begin
        case ({c[`CDB_CTRL_LOOK_BIT], c[`CDB_CTRL_BUFFER_WRITE_REQUEST_BIT], c[`CDB_CTRL_ECC_BIT]})
          3'h0:    mode_of = `CDB_MODE_MONITOR;
          3'h1:    mode_of = `CDB_MODE_REPEAT;
          3'h2:    mode_of = `CDB_MODE_WRITE;
          3'h3:    mode_of = `CDB_MODE_REALTIME;
          3'h6:    mode_of = `CDB_MODE_WRITE_LA;
          3'h7:    mode_of = `CDB_MODE_REAL_LA;
          default: mode_of = `CDB_MODE_INVALID;
        endcase
      end
    end
  endfunction

  // slot comes from the address during setup so the registered read lands in time
  assign mem_idx = hdr_index(paddr[3:2] - 2'h1, subheader_select, header_error_flags);

  cdb_hdr_mem #(
    .DEPTH (`CDB_HDR_BYTES),
    .AW    (4)
  ) u_hdr_mem (
    .core_clk (core_clk),
    .wr_en    (hdr_wr_en & decode_enable), // R16 R14
    .wr_idx   (hdr_wr_idx),
    .wr_data  (hdr_wr_data),
    .rd_idx   (mem_idx),
    .rd_data  (mem_rdata)
  );

  // transfer counter, address and flags
  always @*
  begin
    cnt_next  = cnt_reg;
    addr_next = xfer_addr;
    busy_next = xfer_busy_flag;
    end_next  = xfer_end_flag;
    if (xfer_busy_flag)
    begin
      if ((xfer_to_host & host_read_pulse) | (~xfer_to_host & xfer_byte_pulse)) // R02
      begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0001)
        begin
          busy_next = 1'b0; // R24 R25
          end_next  = 1'b1; // R23 R25
        end
      end
      if (xfer_byte_pulse)
      begin
        addr_next = xfer_addr + 21'h000001; // R04
      end
    end
    if (wr)
    begin
      if (paddr == `CDB_OFS_CNT_LOW)
      begin
        cnt_next[7:0] = pwdata[7:0];
      end
      else if (paddr == `CDB_OFS_CNT_HIGH)
      begin
        cnt_next[15:8] = pwdata[7:0] & {~legacy_mode, 7'h7F}; // R01
      end
      else if (paddr == `CDB_OFS_ADDR_LOW)
      begin
        addr_next[7:0] = pwdata[7:0]; // R03
      end
      else if (paddr == `CDB_OFS_ADDR_MID)
      begin
        addr_next[15:8] = pwdata[7:0]; // R03
      end
      else if (paddr == `CDB_OFS_ADDR_TOP)
      begin
        addr_next[20:16] = pwdata[4:0]; // R03
      end
      else if (paddr == `CDB_OFS_TRIGGER)
      begin
        busy_next = (cnt_reg != 16'h0000); // R11 R24
      end
    end
    // a start with nothing to move ends at once
    if (wr && paddr == `CDB_OFS_TRIGGER && cnt_reg == 16'h0000)
    begin
      end_next = 1'b1; // R25
    end
    else if (wr && paddr == `CDB_OFS_END_ACK && !(end_next && !xfer_end_flag))
    begin
      end_next = 1'b0; // R12
    end
  end

  // drive pointer and block head
  always @*
  begin
    wr_next     = drive_wr_addr;
    head_next   = head_reg;
    park_next   = park_reg;
    active_next = drive_wr_active;
    if (drive_wr_active && drive_byte_pulse)
    begin
      wr_next = drive_wr_addr + 21'h000001; // R09
    end
    if (drive_sync_pulse)
    begin
      active_next = buffer_write_request; // R20
      if (park_reg)
      begin
        wr_next   = head_reg; // R10
        park_next = 1'b0;
      end
      else if (drive_wr_active)
      begin
        // sync marks the tail of the block just written
        head_next = lookahead ? drive_wr_addr : drive_wr_addr - `CDB_BLOCK_LEN; // R07 R08 R17
      end
    end
    if (!buffer_write_request)
    begin
      active_next = 1'b0; // R20
    end
    if (wr)
    begin
      if (drive_wr_active || park_reg)
      begin
        // while writing, bytes are staged in the head register
        if (paddr == `CDB_OFS_WR_LOW)
        begin
          head_next[7:0] = pwdata[7:0]; // R10
        end
        else if (paddr == `CDB_OFS_WR_MID)
        begin
          head_next[15:8] = pwdata[7:0]; // R10
        end
        else if (paddr == `CDB_OFS_WR_TOP)
        begin
          head_next[20:16] = pwdata[4:0]; // R10
          park_next        = 1'b1;
        end
      end
      else if (paddr == `CDB_OFS_WR_LOW)
      begin
        wr_next[7:0] = pwdata[7:0];
      end
      else if (paddr == `CDB_OFS_WR_MID)
      begin
        wr_next[15:8] = pwdata[7:0];
      end
      else if (paddr == `CDB_OFS_WR_TOP)
      begin
        wr_next[20:16] = pwdata[4:0];
      end
    end
  end

  // read mux, evaluated in the first access cycle
  always @*
  begin
    rdata_next = 32'h00000000;
    err_next   = 1'b0;
    if (paddr == `CDB_OFS_CNT_LOW)
    begin
      rdata_next[7:0] = cnt_reg[7:0];
    end
    else if (paddr == `CDB_OFS_CNT_HIGH)
    begin
      rdata_next[7:0] = legacy_mode ? {xfer_end_flag, cnt_reg[14:8]} : cnt_reg[15:8]; // R01
    end
    else if (paddr == `CDB_OFS_HEAD_LOW)
    begin
      rdata_next[7:0] = head_reg[7:0];
    end
    else if (paddr == `CDB_OFS_HEAD_MID)
    begin
      rdata_next[7:0] = head_reg[15:8];
    end
    else if (paddr == `CDB_OFS_HEAD_TOP)
    begin
      rdata_next[7:0] = {3'h0, head_reg[20:16]};
    end
    else if (paddr == `CDB_OFS_WR_LOW)
    begin
      rdata_next[7:0] = drive_wr_addr[7:0];
    end
    else if (paddr == `CDB_OFS_WR_MID)
    begin
      rdata_next[7:0] = drive_wr_addr[15:8];
    end
    else if (paddr == `CDB_OFS_WR_TOP)
    begin
      rdata_next[7:0] = {3'h0, drive_wr_addr[20:16]};
    end
    else if (paddr >= `CDB_OFS_HDR0 && paddr <= `CDB_OFS_HDR3 && paddr[1:0] == 2'h0)
    begin
      rdata_next[7:0] = mem_rdata; // R13 R14
    end
    else if (paddr == `CDB_OFS_CTRL)
    begin
      rdata_next[7:0] = ctrl_reg;
    end
    else if (paddr == `CDB_OFS_STATUS)
    begin
      rdata_next[3:0] = {park_reg, drive_wr_active, xfer_end_flag, xfer_busy_flag};
    end
    else if (paddr == `CDB_OFS_ADDR_LOW || paddr == `CDB_OFS_ADDR_MID || paddr == `CDB_OFS_ADDR_TOP ||
             paddr == `CDB_OFS_TRIGGER || paddr == `CDB_OFS_END_ACK)
    begin
      rdata_next = 32'h00000000; // write-only locations read as zero
    end
    else
    begin
      err_next = 1'b1;
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
      cnt_reg             <= 16'h0000;
      xfer_addr           <= 21'h000000;
      xfer_internal_mem   <= 1'b0;
      xfer_busy_flag      <= 1'b0;
      xfer_end_flag       <= 1'b0;
      head_reg            <= 21'h000000;
      drive_wr_addr       <= 21'h000000;
      park_reg            <= 1'b0;
      drive_wr_active     <= 1'b0;
      ctrl_reg            <= `CDB_CTRL_RESET; // R15
      internal_ram_enable <= 1'b0;
      decode_enable       <= 1'b0;
      lookahead           <= 1'b0;
      fix_upstream_miscorrections <= 1'b0;
      auto_form_extract   <= 1'b0;
      erasure_flag_use    <= 1'b0;
      correction_request  <= 1'b0;
      factory_test_bit    <= 1'b0;
      decoder_mode        <= `CDB_MODE_DISABLED;
    end
    else
    begin
      // one wait state: pready rises in the second access cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_next;
      if (rd)
      begin
        prdata <= rdata_next;
      end
      cnt_reg        <= cnt_next;
      xfer_addr      <= addr_next;
      xfer_busy_flag <= busy_next;
      xfer_end_flag  <= end_next;
      if (wr && paddr == `CDB_OFS_ADDR_TOP)
      begin
        xfer_internal_mem <= pwdata[`CDB_ADDR_SEL_BIT]; // R05
      end
      head_reg        <= head_next;
      drive_wr_addr   <= wr_next;
      park_reg        <= park_next;
      drive_wr_active <= active_next;
      if (wr && paddr == `CDB_OFS_CTRL)
      begin
        ctrl_reg <= pwdata[7:0];
      end
      // control outputs lag the register by one cycle
      decode_enable               <= ctrl_reg[`CDB_CTRL_DECODE_ENABLE_BIT]; // R16
      lookahead                   <= ctrl_reg[`CDB_CTRL_LOOK_BIT]; // R17
      fix_upstream_miscorrections <= ctrl_reg[`CDB_CTRL_FIX_BIT]; // R18
      auto_form_extract           <= ctrl_reg[`CDB_CTRL_AUTO_BIT];
      erasure_flag_use            <= ctrl_reg[`CDB_CTRL_ERAS_BIT]; // R19
      correction_request          <= ctrl_reg[`CDB_CTRL_ECC_BIT] & ctrl_reg[`CDB_CTRL_DECODE_ENABLE_BIT]; // R21 R16
      factory_test_bit            <= ctrl_reg[`CDB_CTRL_TEST_BIT];
      internal_ram_enable         <= buffer_write_request; // R20
      decoder_mode                <= mode_of(ctrl_reg); // R22
    end
  end

endmodule // cdb_regs

`default_nettype wire

/* File: verification/cdb_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdb_defs.vh"

module cdb_checker (
  // clock, reset and register bus
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // byte and block events
  input wire logic        xfer_byte_pulse,
  input wire logic        drive_byte_pulse,
  input wire logic        drive_sync_pulse,
  // transfer and drive state
  input wire logic        xfer_busy_flag,
  input wire logic        xfer_end_flag,
  input wire logic        xfer_internal_mem,
  input wire logic        drive_wr_active,
  input wire logic [20:0] xfer_addr,
  input wire logic [20:0] drive_wr_addr,
  // decoder control outputs
  input wire logic        decode_enable,
  input wire logic        lookahead,
  input wire logic        factory_test_bit,
  input wire logic        correction_request,
  input wire logic [2:0]  decoder_mode
);
  wire wr;
  assign wr = psel && penable && pready && pwrite;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_trigger_starts: assert property (wr && paddr == `CDB_OFS_TRIGGER |=> xfer_busy_flag || xfer_end_flag)
    else $error("trigger write started nothing");
  a_ack_clears: assert property (wr && paddr == `CDB_OFS_END_ACK && !xfer_busy_flag |=> !xfer_end_flag)
    else $error("acknowledge left end flag set");
  a_end_at_zero: assert property ($fell(xfer_busy_flag) |-> xfer_end_flag)
    else $error("busy fell without end flag");
  a_addr_steps: assert property (xfer_byte_pulse && xfer_busy_flag && !wr
    |=> xfer_addr - $past(xfer_addr) == 21'h000001)
    else $error("transfer address did not step by one");
  a_drive_steps: assert property (drive_byte_pulse && drive_wr_active && !drive_sync_pulse && !wr
    |=> drive_wr_addr - $past(drive_wr_addr) == 21'h000001)
    else $error("drive pointer did not step by one");
  a_drive_start: assert property ($rose(drive_wr_active) |-> $past(drive_sync_pulse))
    else $error("drive writes began off a block sync");
  a_ctrl_follow: assert property (wr && paddr == `CDB_OFS_CTRL |-> ##2
    {decode_enable, lookahead, factory_test_bit} == {$past(pwdata[7], 2), $past(pwdata[6], 2), $past(pwdata[0], 2)})
    else $error("control outputs do not follow written value");
  a_ecc_gated: assert property (correction_request |-> decode_enable)
    else $error("correction active with decoding off");
  a_mode_off: assert property (!decode_enable |-> decoder_mode == `CDB_MODE_DISABLED)
    else $error("decoder mode not disabled");
  a_mem_select: assert property (wr && paddr == `CDB_OFS_ADDR_TOP |=> xfer_internal_mem == $past(pwdata[7]))
    else $error("memory select not taken from top address byte");
endmodule // cdb_checker

bind cdb_regs cdb_checker i_chk (.*);

`default_nettype wire

/* File: verification/cdb_far_end.sv */
`timescale 1ns/1ps
`default_nettype none

module cdb_far_end (
  // clock and engine state
  input  wire logic       core_clk,
  input  wire logic       xfer_busy_flag,
  input  wire logic       xfer_to_host,
  input  wire logic [3:0] gap,
  // byte and block events
  output logic            host_read_pulse,
  output logic            xfer_byte_pulse,
  output logic            drive_byte_pulse,
  output logic            drive_sync_pulse
);
  logic [3:0] cnt_reg;

  // the engine pulses settle to zero during reset, while busy is low
  initial {drive_byte_pulse, drive_sync_pulse} = 2'b00;

  // gap sets the pace; a gap of zero would overrun the end of the count by one byte
  always @(posedge core_clk)
  begin
    cnt_reg <= (xfer_busy_flag && cnt_reg != gap) ? cnt_reg + 4'h1 : 4'h0;
    xfer_byte_pulse <= xfer_busy_flag && cnt_reg == gap;
    host_read_pulse <= xfer_busy_flag && cnt_reg == gap && xfer_to_host;
  end

  // one sync, a short block of bytes, then the next sync
  task drive_run(input int n);
    @(posedge core_clk) drive_sync_pulse <= 1'b1;
    @(posedge core_clk) drive_sync_pulse <= 1'b0;
    repeat (n)
    begin
      @(posedge core_clk) drive_byte_pulse <= 1'b1;
      @(posedge core_clk) drive_byte_pulse <= 1'b0;
    end
    @(posedge core_clk) drive_sync_pulse <= 1'b1;
    @(posedge core_clk) drive_sync_pulse <= 1'b0;
  endtask
endmodule // cdb_far_end

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdb_defs.vh"

module testbench;
  logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0]  paddr = 8'h00, hdr_wr_data = 8'h00, header_error_flags = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        legacy_mode = 1, xfer_to_host = 0, hdr_wr_en = 0, subheader_select = 0;
  logic [3:0]  hdr_wr_idx = 4'h0, gap = 4'h1;
  logic        pready, pslverr, xfer_busy_flag, xfer_end_flag, xfer_internal_mem, drive_wr_active;
  logic        internal_ram_enable, decode_enable, lookahead, fix_upstream_miscorrections;
  logic        auto_form_extract, erasure_flag_use, correction_request, factory_test_bit;
  logic [20:0] xfer_addr, drive_wr_addr;
  logic [2:0]  decoder_mode;
  wire         host_read_pulse, xfer_byte_pulse, drive_byte_pulse, drive_sync_pulse;
  int          mismatches = 0, n_tests = 0;

  always #2 core_clk = ~core_clk;

  cdb_regs i_dut (.*);
  cdb_far_end i_far (.*);

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task t_reset;
    apb(0, `CDB_OFS_CTRL, 0); chk("ctrl", rd, 32'h0);
    apb(0, `CDB_OFS_ADDR_LOW, 0); chk("addr_rd", rd, 32'h0);
    apb(0, 8'hFC, 0); chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    $display("reset done");
  endtask

  task t_modes;
    logic [7:0] cv [8] = '{8'h02, 8'h80, 8'h82, 8'h84, 8'h86, 8'hC4, 8'hC6, 8'hC0};
    for (int i = 0; i < 8; i++)
    begin
      apb(1, `CDB_OFS_CTRL, {24'h0, cv[i]});
      apb(0, `CDB_OFS_CTRL, 0); chk("ctrl", rd, {24'h0, cv[i]});
      chk("mode", decoder_mode, i);
      chk("ecc", correction_request, cv[i][7] & cv[i][1]);
    end
    apb(1, `CDB_OFS_CTRL, 32'h28);
    repeat (2) @(posedge core_clk);
    chk("fix", fix_upstream_miscorrections, 1);
    chk("erasure", erasure_flag_use, 1);
    chk("ram_en", {auto_form_extract, factory_test_bit, internal_ram_enable}, 0);
    $display("modes done");
  endtask

  task automatic t_xfer;
    for (int k = 0; k < 2; k++)
    begin
      xfer_to_host <= k[0]; legacy_mode <= !k[0]; gap <= k ? 4'h3 : 4'h1;
      apb(1, `CDB_OFS_CNT_LOW, 3); apb(1, `CDB_OFS_CNT_HIGH, 0);
      apb(1, `CDB_OFS_ADDR_LOW, 8'h10); apb(1, `CDB_OFS_ADDR_MID, 8'h20); apb(1, `CDB_OFS_ADDR_TOP, 8'h81);
      apb(1, `CDB_OFS_TRIGGER, 8'h5A);
      @(posedge core_clk); chk("busy", xfer_busy_flag, 1);
      while (xfer_end_flag !== 1'b1) @(posedge core_clk);
      chk("busy", xfer_busy_flag, 0);
      chk("xaddr", xfer_addr, 21'h012013);
      chk("mem", xfer_internal_mem, 1);
      apb(0, `CDB_OFS_CNT_HIGH, 0); chk("cnt_high", rd, {!k[0], 7'h0});
      apb(1, `CDB_OFS_END_ACK, 8'hFF); apb(0, `CDB_OFS_CNT_HIGH, 0); chk("cnt_high", rd, 0);
    end
    apb(1, `CDB_OFS_TRIGGER, 0);
    repeat (2) @(posedge core_clk);
    chk("end", xfer_end_flag, 1);
    apb(1, `CDB_OFS_END_ACK, 0);
    $display("transfer done");
  endtask

  task t_header;
    apb(1, `CDB_OFS_CTRL, 8'h80);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge core_clk);
      hdr_wr_en <= 1; hdr_wr_idx <= i[3:0]; hdr_wr_data <= 8'hA0 + i[7:0];
    end
    @(posedge core_clk) hdr_wr_en <= 0;
    apb(0, `CDB_OFS_HDR3, 0); chk("hdr3", rd, 32'hA3);
    subheader_select <= 1;
    apb(0, `CDB_OFS_HDR0, 0); chk("sub0", rd, 32'hA8);
    header_error_flags <= 8'h08;
    apb(0, `CDB_OFS_HDR0, 0); chk("sub0_copy", rd, 32'hA4);
    header_error_flags <= 8'h00; subheader_select <= 0;
    $display("header done");
  endtask

  task t_drive;
    apb(1, `CDB_OFS_CTRL, 0);
    apb(1, `CDB_OFS_WR_LOW, 0); apb(1, `CDB_OFS_WR_MID, 8'h10); apb(1, `CDB_OFS_WR_TOP, 0);
    apb(1, `CDB_OFS_CTRL, 8'h84);
    repeat (2) @(posedge core_clk);
    chk("ram_en", internal_ram_enable, 1);
    i_far.drive_run(5);
    repeat (3) @(posedge core_clk);
    chk("wptr", drive_wr_addr, 21'h001005);
    apb(0, `CDB_OFS_HEAD_LOW, 0); chk("head_low", rd, 32'hD5);
    apb(0, `CDB_OFS_HEAD_MID, 0); chk("head_mid", rd, 32'h06);
    // a new pointer written while writing waits for the next sync
    apb(1, `CDB_OFS_WR_LOW, 8'h40); apb(1, `CDB_OFS_WR_MID, 8'h20); apb(1, `CDB_OFS_WR_TOP, 8'h01);
    chk("wptr_held", drive_wr_addr, 21'h001005);
    i_far.drive_run(0);
    repeat (3) @(posedge core_clk);
    chk("wptr_park", drive_wr_addr, 21'h012040);
    apb(1, `CDB_OFS_CTRL, 8'hC4);
    i_far.drive_run(0);
    apb(0, `CDB_OFS_HEAD_LOW, 0); chk("head_look", rd, 32'h40);
    apb(1, `CDB_OFS_CTRL, 0);
    repeat (3) @(posedge core_clk);
    chk("active", {drive_wr_active, internal_ram_enable}, 0);
    apb(0, `CDB_OFS_WR_LOW, 0); chk("wr_low", rd, 32'h40);
    $display("drive done");
  endtask

  initial
  begin
    #200000;
    mismatches++;
    tally_and_finish;
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 0;
    t_reset;
    t_modes;
    t_xfer;
    t_header;
    t_drive;
    tally_and_finish;
  end
endmodule // testbench

`default_nettype wire
